// [include/pc_shadow_defines.vh]
// offsets, field widths, reset values for the program counter and debug shadow bank
// assumes: included by bare name from verilog/ and bench/ sources
`ifndef PC_SHADOW_DEFINES_VH
`define PC_SHADOW_DEFINES_VH
`define ADDR_W 12
`define PC_W 15
`define OFF_COUNTER_LOW 12'h002
`define OFF_COUNTER_LATCH 12'h00A
`define OFF_STATUS_COPY 12'hFE4
`define OFF_WORKING_COPY 12'hFE5
`define OFF_BANK_COPY 12'hFE6
`define OFF_LATCH_COPY 12'hFE7
`define OFF_PTR0L_COPY 12'hFE8
`define OFF_PTR0H_COPY 12'hFE9
`define OFF_PTR1L_COPY 12'hFEA
`define OFF_PTR1H_COPY 12'hFEB
`define OFF_STACK_PTR 12'hFED
`define OFF_STACK_TOP_LOW 12'hFEE
`define OFF_STACK_TOP_HIGH 12'hFEF
`define BANK31_HI 5'h1F
`define MASK_STATUS 8'h07
`define MASK_BANK 8'h1F
`define MASK_LATCH 8'h7F
`define MASK_STACK_LEVEL_POINTER 8'h1F
`define MASK_TOS_HIGH 8'h7F
`define STACK_DEPTH 16
`define STACK_LEVEL_POINTER_RESET 5'h1F
`define PC_RESET 15'h0000
`endif

// [verilog/stack_store.v]
// sixteen-entry by fifteen-bit return stack storage, flip-flops addressed by index
// assumes: same clock as the register bank; one write per cycle
`timescale 1ns/1ps
`default_nettype none
`include "pc_shadow_defines.vh"
module stack_store (
  input wire i_clk, // core clock
  input wire i_rst_b, // async reset, active low
  input wire [3:0] i_idx, // entry selected by stack pointer
  input wire i_wr_lo, // write low byte of entry
  input wire i_wr_hi, // write high seven bits of entry
  input wire [7:0] i_wdata, // write data
  output wire [`PC_W-1:0] o_entry // selected entry
);
  // entries are gathered on one flat bus so each flip-flop group has a single driver
  wire [`PC_W*`STACK_DEPTH-1:0] entries_flat;
  genvar g;
  generate
    for (g = 0; g < `STACK_DEPTH; g = g + 1)
    begin : gen_entry
      localparam integer ENTRY_IDX = g;
      reg [`PC_W-1:0] entry_q;
      always @(posedge i_clk or negedge i_rst_b)
      begin
        if (!i_rst_b)
          entry_q <= `PC_RESET;
        else if ({28'h0000000, i_idx} == ENTRY_IDX)
        begin
          if (i_wr_lo)
            entry_q[7:0] <= i_wdata;
          if (i_wr_hi)
            entry_q[14:8] <= i_wdata[6:0];
        end
      end
      assign entries_flat[g*`PC_W +: `PC_W] = entry_q;
    end
  endgenerate
  assign o_entry = entries_flat[i_idx*`PC_W +: `PC_W];
endmodule
`default_nettype wire

// [verilog/pc_shadow_regs.v]
// program counter with counter-low and latch registers, plus the debug shadow bank
// assumes: register port driven by the core on i_clk; debug state given by i_debug_mode
//
// Contract
// - program counter is fifteen bits, positions fourteen down to zero
// - counter low byte is a software readable and writable register
// - upper seven bits are not software visible; loaded only from the latch
// - every reset clears the whole program counter to zero
// - highest bank reachable only in debug mode unless flagged shared
// - shared-flagged registers reachable from user code and the debugger
// - shadow copies of working, status, bank, latch and both pointer pairs
// - unimplemented addresses and bits read zero, writes ignored
// - writing counter low loads upper seven bits from the latch at once
// - stack top pair reads and writes the entry chosen by stack pointer
`timescale 1ns/1ps
`default_nettype none
`include "pc_shadow_defines.vh"
module pc_shadow_regs (
  input wire i_clk, // 20 MHz core clock
  input wire i_rst_b, // async reset, active low
  input wire [`ADDR_W-1:0] i_addr, // register address
  input wire [7:0] i_wdata, // write data
  input wire i_wr, // write strobe
  input wire i_rd, // read strobe
  output reg [7:0] o_rdata, // read data, cycle after strobe
  input wire i_debug_mode, // debug executive running
  input wire i_pc_inc, // core advances counter by one
  input wire [7:0] i_live_status, // live status flags
  input wire [7:0] i_live_working, // live working register
  input wire [7:0] i_live_bank, // live bank select
  input wire [7:0] i_live_ptr0l, // live pointer 0 low
  input wire [7:0] i_live_ptr0h, // live pointer 0 high
  input wire [7:0] i_live_ptr1l, // live pointer 1 low
  input wire [7:0] i_live_ptr1h, // live pointer 1 high
  output reg [`PC_W-1:0] o_pc, // program counter
  output wire [6:0] o_counter_high_latch // latch value
);
  ////////////////////////////////////////////////////////////////////////////
  // decode
  reg [6:0] counter_high_latch_q;
  reg [2:0] status_copy_q;
  reg [7:0] working_copy_q;
  reg [4:0] bank_copy_q;
  reg [6:0] latch_copy_q;
  reg [7:0] ptr0l_copy_q;
  reg [7:0] ptr0h_copy_q;
  reg [7:0] ptr1l_copy_q;
  reg [7:0] ptr1h_copy_q;
  reg [4:0] stack_ptr_q;
  reg debug_q;
  wire [`PC_W-1:0] tos_entry;
  wire in_bank31 = (i_addr[11:7] == `BANK31_HI);
  // every implemented bank-31 register here is flagged shared, so user code passes
  wire bank_ok = !in_bank31 || i_debug_mode || (i_addr >= `OFF_STATUS_COPY);
  wire wr_ok = i_wr && bank_ok;
  wire wr_pcl = wr_ok && (i_addr == `OFF_COUNTER_LOW);
  wire wr_tos_lo = wr_ok && (i_addr == `OFF_STACK_TOP_LOW);
  wire wr_tos_hi = wr_ok && (i_addr == `OFF_STACK_TOP_HIGH);
  wire enter_debug = i_debug_mode && !debug_q;
  assign o_counter_high_latch = counter_high_latch_q;

  ////////////////////////////////////////////////////////////////////////////
  // program counter
  always @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_pc <= `PC_RESET;
    else if (wr_pcl)
      o_pc <= {counter_high_latch_q, i_wdata};
    else if (i_pc_inc)
      o_pc <= o_pc + 15'h0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // latch, shadows, stack pointer
  always @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      counter_high_latch_q <= 7'h00;
      status_copy_q <= 3'h0;
      working_copy_q <= 8'h00;
      bank_copy_q <= 5'h00;
      latch_copy_q <= 7'h00;
      ptr0l_copy_q <= 8'h00;
      ptr0h_copy_q <= 8'h00;
      ptr1l_copy_q <= 8'h00;
      ptr1h_copy_q <= 8'h00;
      stack_ptr_q <= `STACK_LEVEL_POINTER_RESET;
      debug_q <= 1'b0;
    end
    else
    begin
      debug_q <= i_debug_mode;
      if (enter_debug)
      begin
        // capture wins over a software write in the same cycle
        status_copy_q <= i_live_status[2:0];
        working_copy_q <= i_live_working;
        bank_copy_q <= i_live_bank[4:0];
        latch_copy_q <= counter_high_latch_q;
        ptr0l_copy_q <= i_live_ptr0l;
        ptr0h_copy_q <= i_live_ptr0h;
        ptr1l_copy_q <= i_live_ptr1l;
        ptr1h_copy_q <= i_live_ptr1h;
      end
      else if (wr_ok)
      begin
        case (i_addr)
          `OFF_STATUS_COPY: status_copy_q <= i_wdata[2:0];
          `OFF_WORKING_COPY: working_copy_q <= i_wdata;
          `OFF_BANK_COPY: bank_copy_q <= i_wdata[4:0];
          `OFF_LATCH_COPY: latch_copy_q <= i_wdata[6:0];
          `OFF_PTR0L_COPY: ptr0l_copy_q <= i_wdata;
          `OFF_PTR0H_COPY: ptr0h_copy_q <= i_wdata;
          `OFF_PTR1L_COPY: ptr1l_copy_q <= i_wdata;
          `OFF_PTR1H_COPY: ptr1h_copy_q <= i_wdata;
          default:
          begin
          end
        endcase
      end
      if (wr_ok && i_addr == `OFF_COUNTER_LATCH)
        counter_high_latch_q <= i_wdata[6:0];
      if (wr_ok && i_addr == `OFF_STACK_PTR)
        stack_ptr_q <= i_wdata[4:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stack storage; pointer bit 4 is stored and read back but never indexes, entry uses low four
  stack_store u_stack (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_idx(stack_ptr_q[3:0]),
    .i_wr_lo(wr_tos_lo),
    .i_wr_hi(wr_tos_hi),
    .i_wdata(i_wdata),
    .o_entry(tos_entry)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read path
  reg [7:0] rd_d;
  always @*
  begin
    rd_d = 8'h00;
    if (bank_ok)
    begin
      case (i_addr)
        `OFF_COUNTER_LOW: rd_d = o_pc[7:0];
        `OFF_COUNTER_LATCH: rd_d = {1'b0, counter_high_latch_q};
        `OFF_STATUS_COPY: rd_d = {5'h00, status_copy_q} & `MASK_STATUS;
        `OFF_WORKING_COPY: rd_d = working_copy_q;
        `OFF_BANK_COPY: rd_d = {3'h0, bank_copy_q} & `MASK_BANK;
        `OFF_LATCH_COPY: rd_d = {1'b0, latch_copy_q} & `MASK_LATCH;
        `OFF_PTR0L_COPY: rd_d = ptr0l_copy_q;
        `OFF_PTR0H_COPY: rd_d = ptr0h_copy_q;
        `OFF_PTR1L_COPY: rd_d = ptr1l_copy_q;
        `OFF_PTR1H_COPY: rd_d = ptr1h_copy_q;
        `OFF_STACK_PTR: rd_d = {3'h0, stack_ptr_q} & `MASK_STACK_LEVEL_POINTER;
        `OFF_STACK_TOP_LOW: rd_d = tos_entry[7:0];
        `OFF_STACK_TOP_HIGH: rd_d = {1'b0, tos_entry[14:8]} & `MASK_TOS_HIGH;
        default: rd_d = 8'h00;
      endcase
    end
  end

  always @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_rdata <= 8'h00;
    else if (i_rd)
      o_rdata <= rd_d;
    else
      o_rdata <= 8'h00;
  end
endmodule
`default_nettype wire

// [bench/pc_shadow_monitor.sv]
// assertions on the program counter and register port of pc_shadow_regs
// assumes: bound to pc_shadow_regs, one clock, async active-low reset
`timescale 1ns/1ps
`default_nettype none
`include "pc_shadow_defines.vh"
module pc_shadow_monitor (
  input wire logic i_clk, // clock
  input wire logic i_rst_b, // reset
  input wire logic [11:0] i_addr, // address
  input wire logic [7:0] i_wdata, // data
  input wire logic i_wr, // write
  input wire logic i_rd, // read
  input wire logic i_pc_inc, // step
  input wire logic [7:0] o_rdata, // read data
  input wire logic [14:0] o_pc, // counter
  input wire logic [6:0] o_counter_high_latch // latch
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  wire logic lw = i_wr && i_addr == `OFF_COUNTER_LOW;
  wire logic hw = i_wr && i_addr == `OFF_COUNTER_LATCH;
  pc_load_a: assert property (lw |=> o_pc == {$past(o_counter_high_latch), $past(i_wdata)})
    else $error("counter load wrong");
  pc_step_a: assert property (i_pc_inc && !lw |=> o_pc == $past(o_pc) + 15'h0001)
    else $error("counter step wrong");
  pc_hold_a: assert property (!i_pc_inc && !lw |=> $stable(o_pc))
    else $error("counter moved");
  latch_load_a: assert property (hw |=> o_counter_high_latch == $past(i_wdata[6:0]))
    else $error("latch load wrong");
  latch_hold_a: assert property (!hw |=> $stable(o_counter_high_latch))
    else $error("latch moved");
  rd_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not idle");
  rd_low_a: assert property (i_rd && i_addr == `OFF_COUNTER_LOW |=> o_rdata == $past(o_pc[7:0]))
    else $error("counter low read wrong");
  rd_latch_a: assert property (i_rd && i_addr == `OFF_COUNTER_LATCH |=> o_rdata == {1'b0, $past(o_counter_high_latch)})
    else $error("latch read wrong");
  rd_debug_a: assert property (i_rd && i_addr >= 12'hF80 && i_addr < 12'hFE4 |=> o_rdata == 8'h00)
    else $error("debug-only read not zero");
  cover property (lw);
  cover property (i_pc_inc && !lw);
  cover property (i_rd && i_addr == `OFF_STACK_TOP_HIGH);
endmodule
bind pc_shadow_regs pc_shadow_monitor pc_shadow_monitor_inst (.*);
`default_nettype wire

// [bench/tb_top.sv]
// self-checking bench: random port traffic against an integer model
// assumes: pc_shadow_regs and its monitor compiled before this file
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 0, rst_b = 0, wr = 0, rd = 0, dbg = 0, inc = 0;
  logic [11:0] addr = 12'h000;
  logic [7:0] wd = 8'h00, lv [7] = '{default: 8'h00};
  wire logic [7:0] rdata;
  wire logic [14:0] pc;
  wire logic [6:0] lat;
  int bad_count = 0, checks_done = 0, cyc = 0, k, mpc = 0, mlat = 0, msp = 'h1F, mrd = 0;
  int sh [8] = '{default: 0}, stk [16] = '{default: 0};
  int mk [8] = '{'h07, 'hFF, 'h1F, 'h7F, 'hFF, 'hFF, 'hFF, 'hFF};
  int ad [4] = '{'h002, 'h00A, 'hF90, 'h123};
  bit pdbg = 0;
  pc_shadow_regs pc_shadow_regs_inst (.i_clk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wd), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_debug_mode(dbg), .i_pc_inc(inc), .i_live_status(lv[0]),
    .i_live_working(lv[1]), .i_live_bank(lv[2]), .i_live_ptr0l(lv[3]), .i_live_ptr0h(lv[4]),
    .i_live_ptr1l(lv[5]), .i_live_ptr1h(lv[6]), .o_pc(pc), .o_counter_high_latch(lat));
  initial forever #25 clk = ~clk;
  function automatic int rdv(int a);
    int s;
    s = msp & 15;
    if (a == 'h002) return mpc & 'hFF;
    if (a >= 'hFE4 && a <= 'hFEB) return sh[a - 'hFE4];
    if (a == 'hFED) return msp;
    if (a == 'hFEE) return stk[s] & 'hFF;
    if (a == 'hFEF) return stk[s] >> 8;
    return a == 'h00A ? mlat : 0;
  endfunction
  function automatic void wrv(int a, int d);
    int s;
    s = msp & 15;
    if (a == 'h00A) mlat = d & 'h7F;
    if (a >= 'hFE4 && a <= 'hFEB) sh[a - 'hFE4] = d & mk[a - 'hFE4];
    if (a == 'hFED) msp = d & 'h1F;
    if (a == 'hFEE) stk[s] = stk[s] & 'h7F00 | d;
    if (a == 'hFEF) stk[s] = stk[s] & 'hFF | (d & 'h7F) << 8;
  endfunction
  // model samples the pre-edge inputs, the same view the design gets
  always @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      mpc = 0;
      mlat = 0;
      msp = 'h1F;
      mrd = 0;
      pdbg = 0;
      sh = '{default: 0};
      stk = '{default: 0};
    end
    else
    begin
      mrd = rd ? rdv(addr) : 0;
      if (wr && addr == 'h002) mpc = mlat << 8 | wd;
      else if (inc) mpc = (mpc + 1) & 'h7FFF;
      if (wr) wrv(addr, wd);
      if (dbg && !pdbg)
        foreach (sh[i])
          sh[i] = (i == 3 ? mlat : lv[i - (i > 3)]) & mk[i];
      pdbg = dbg;
    end
  task automatic cmp(logic [14:0] g, logic [14:0] e);
    checks_done++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic conclude();
    if (bad_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(negedge clk)
  begin
    cmp({7'h00, rdata}, mrd[14:0]);
    cmp(pc, mpc[14:0]);
    cmp({8'h00, lat}, mlat[14:0]);
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      bad_count++;
      conclude();
    end
  end
  initial
  begin
    void'($urandom(79223));
    repeat (8) @(posedge clk);
    rst_b <= 1;
    for (int n = 0; n < 3000; n++)
    begin
      @(posedge clk);
      k = $urandom % 3;
      wr <= k == 0;
      rd <= k == 1;
      addr <= $urandom % 4 ? 12'hFE4 + 12'($urandom % 16) : 12'(ad[$urandom % 4]);
      wd <= 8'($urandom);
      inc <= 1'($urandom);
      foreach (lv[i]) lv[i] <= 8'($urandom);
      // debug toggles only on idle cycles, so no write races the capture except at reset release with dbg still high
      if (k == 2 && $urandom % 8 == 0) dbg <= !dbg;
      if (n == 1500) rst_b <= 0;
      if (n == 1503) rst_b <= 1;
    end
    conclude();
  end
endmodule
`default_nettype wire
